// [rtl/silc_id_word.sv]
// packs the build-time identification words (constant, side-effect free)
`timescale 1ns/1ps
module silc_id_word
  import silc_pkg::*;
#(
  parameter logic [7:0] VER_MAJOR = 8'h01, // arbitrary
  parameter logic [7:0] VER_MINOR = 8'h00, // arbitrary
  parameter logic [3:0] VER_REV = 4'h0, // arbitrary
  parameter logic [3:0] VER_PATCH = 4'h0, // arbitrary
  parameter logic [7:0] VER_INTERNAL = 8'h00, // arbitrary
  parameter logic [7:0] PROTO_MAJOR = 8'h01, // arbitrary
  parameter logic [7:0] PROTO_MINOR = 8'h00, // arbitrary
  parameter logic [7:0] PROTO_REV = 8'h00 // arbitrary
)
(
  output wire logic [silc_pkg::SILC_DW-1:0] o_rev_word,
  output wire logic [silc_pkg::SILC_DW-1:0] o_proto_word
);
  import silc_pkg::*;

  // R1 version field packing
  assign o_rev_word[SILC_VER_MAJOR_LSB +: 8] = VER_MAJOR; // major version
  assign o_rev_word[SILC_VER_MINOR_LSB +: 8] = VER_MINOR; // minor version
  assign o_rev_word[SILC_VER_REV_LSB +: 4] = VER_REV; // revision
  assign o_rev_word[SILC_VER_PATCH_LSB +: 4] = VER_PATCH; // patch level
  assign o_rev_word[SILC_VER_INT_LSB +: 8] = VER_INTERNAL; // internal revision
  // R2 protocol version fields
  assign o_proto_word[SILC_ID_PMAJ_LSB +: 8] = PROTO_MAJOR; // protocol major
  assign o_proto_word[SILC_ID_PMIN_LSB +: 8] = PROTO_MINOR; // protocol minor
  assign o_proto_word[SILC_ID_PREV_LSB +: 8] = PROTO_REV; // protocol revision
  // R3 role byte fixed at receive
  assign o_proto_word[SILC_ID_ROLE_LSB +: 8] = SILC_ROLE_RX;
endmodule

// [rtl/silc_pkg.sv]
// constants for the sink identity and link capability register bank
// Notes on behaviour
// R1 - read-only version word, five packed fields
// R2 - read-only identity word, protocol version fields
// R3 - identity low byte: zero transmit, one receive
// R4 - writable link rate, advertised to source
// R5 - writable lane count, advertised to source
// R6 - identity words ignore writes, reads harmless
package silc_pkg;
  // register byte offsets
  localparam logic [11:0] SILC_OFF_LINK_RATE = 12'h09C;
  localparam logic [11:0] SILC_OFF_LANE_CNT = 12'h0A0;
  localparam logic [11:0] SILC_OFF_REV_INFO = 12'h0F8;
  localparam logic [11:0] SILC_OFF_PROTO_ID = 12'h0FC;
  // address and data widths
  localparam int SILC_AW = 12;
  localparam int SILC_DW = 32;
  // version word field positions (low bit of each field)
  localparam int SILC_VER_MAJOR_LSB = 24;
  localparam int SILC_VER_MINOR_LSB = 16;
  localparam int SILC_VER_REV_LSB = 12;
  localparam int SILC_VER_PATCH_LSB = 8;
  localparam int SILC_VER_INT_LSB = 0;
  // identity word field positions
  localparam int SILC_ID_PMAJ_LSB = 24;
  localparam int SILC_ID_PMIN_LSB = 16;
  localparam int SILC_ID_PREV_LSB = 8;
  localparam int SILC_ID_ROLE_LSB = 0;
  // role encodings
  localparam logic [7:0] SILC_ROLE_TX = 8'h00;
  localparam logic [7:0] SILC_ROLE_RX = 8'h01;
  // reset values of the capability registers (arbitrary plain defaults)
  localparam logic [7:0] SILC_LINK_RATE_RST = 8'h0A;
  localparam logic [4:0] SILC_LANE_CNT_RST = 5'h04;
  // unmapped reads answer zero
  localparam logic [31:0] SILC_RD_UNMAPPED = 32'h0000_0000;
endpackage

// [rtl/silc_regs.sv]
// sink identity and advertised link capability register bank
`timescale 1ns/1ps
module silc_regs
  import silc_pkg::*;
#(
  parameter int RATE_W = 8, // width of advertised link rate code
  parameter int LANE_W = 5 // width of advertised lane count
)
(
  input wire logic i_mclk, // 10 MHz system clock
  input wire logic i_nrst, // synchronous reset, active low
  input wire logic [silc_pkg::SILC_AW-1:0] i_addr, // byte address
  input wire logic [silc_pkg::SILC_DW-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [silc_pkg::SILC_DW-1:0] o_rdata, // read data, cycle after strobe
  output logic [RATE_W-1:0] o_adv_link_rate, // rate shown to source
  output logic [LANE_W-1:0] o_adv_lane_count // lanes shown to source
);
  import silc_pkg::*;

  // operation in brief:
  // - two capability words hold what the receiver advertises;
  //   the source side picks them up from o_adv_link_rate and
  //   o_adv_lane_count, which follow a write on the next edge
  // - two identification words are wired constants, so a read
  //   of them changes nothing and a write to them is dropped
  // - every read answers one cycle after its strobe and the read
  //   port returns to zero the cycle after, so a host that samples
  //   late sees zero rather than stale data
  // - no wait states: the host never has to poll a ready flag

  // refuse widths that do not fit the word or the reset values;
  // narrower fields would cut the reset codes, wider ones overrun the word
  if (RATE_W < 8 || RATE_W > SILC_DW || LANE_W < 5 || LANE_W > SILC_DW)
  begin
    $error("silc_regs: unsupported field width");
  end

  // fixed identity words
  logic [SILC_DW-1:0] rev_word;
  logic [SILC_DW-1:0] proto_word;

  silc_id_word u_id
  (
    .o_rev_word(rev_word),
    .o_proto_word(proto_word)
  );

  // register map seen by the host, byte addresses:
  //   link rate word  - read/write, low RATE_W bits kept
  //   lane count word - read/write, low LANE_W bits kept
  //   version word    - read only, fixed at build time
  //   identity word   - read only, fixed at build time
  // full-address compare: aliases would let a stray pointer
  // reprogram what the source is told, so nothing is folded
  // address decode, one select per register
  wire sel_rate = (i_addr == SILC_OFF_LINK_RATE); // link rate word
  wire sel_lane = (i_addr == SILC_OFF_LANE_CNT); // lane count word
  wire sel_rev = (i_addr == SILC_OFF_REV_INFO); // version word
  wire sel_proto = (i_addr == SILC_OFF_PROTO_ID); // identity word
  // any mapped offset; reads elsewhere answer zero
  wire sel_any = sel_rate || sel_lane || sel_rev || sel_proto;
  // qualified write strobes; only the two capability words take writes
  wire wr_rate = i_wr && sel_rate;
  wire wr_lane = i_wr && sel_lane;
  // read strobes per register, watched by the checks
  wire rd_rate = i_rd && sel_rate;
  wire rd_lane = i_rd && sel_lane;
  wire rd_rev = i_rd && sel_rev;
  wire rd_proto = i_rd && sel_proto;
  wire rd_none = i_rd && !sel_any;

  // capability registers
  logic [RATE_W-1:0] rate_q;
  logic [RATE_W-1:0] rate_d;
  logic [LANE_W-1:0] lane_q;
  logic [LANE_W-1:0] lane_d;
  logic [SILC_DW-1:0] rdata_d;
  // reset codes at field width; the source sees these until software writes
  wire [RATE_W-1:0] rate_rst = RATE_W'(SILC_LINK_RATE_RST);
  wire [LANE_W-1:0] lane_rst = LANE_W'(SILC_LANE_CNT_RST);

  // only the low bits of the bus word are kept; the rest are
  // dropped here and read back as zero
  // R4 link rate write
  assign rate_d = wr_rate ? i_wdata[RATE_W-1:0] : rate_q;
  // R5 lane count write
  assign lane_d = wr_lane ? i_wdata[LANE_W-1:0] : lane_q;

  // read mux; narrow fields zero-extended, unmapped reads zero
  // gated by the read strobe so the port idles at zero between reads
  // R6 identity reads side-effect free
  wire [SILC_DW-1:0] rate_ext = SILC_DW'(rate_q);
  wire [SILC_DW-1:0] lane_ext = SILC_DW'(lane_q);
  assign rdata_d = !i_rd ? SILC_RD_UNMAPPED :
                   sel_rate ? rate_ext :
                   sel_lane ? lane_ext :
                   sel_rev ? rev_word :
                   sel_proto ? proto_word : SILC_RD_UNMAPPED;

  // register state; writes to identity offsets land nowhere
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      // defaults until software programs the capabilities
      rate_q <= rate_rst;
      lane_q <= lane_rst;
      o_rdata <= SILC_RD_UNMAPPED;
    end
    else
    begin
      rate_q <= rate_d;
      lane_q <= lane_d;
      o_rdata <= rdata_d;
    end
  end

  // capability outputs come from their own flops
  // they load the next value, not rate_q, so they never lag the readback
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_adv_link_rate <= rate_rst;
      o_adv_lane_count <= lane_rst;
    end
    else
    begin
      o_adv_link_rate <= rate_d;
      o_adv_lane_count <= lane_d;
    end
  end

  // checks: each watches what this bank drives toward the host or the source;
  // the strobes come from the host and are not policed here;
  // the reset checks run without disable so that the defaults are seen

  // R4 write reaches source
  rate_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R4
    wr_rate |=> (o_adv_link_rate == $past(i_wdata[RATE_W-1:0])))
    else $error("link rate not advertised after write");

  // R5 write reaches source
  lane_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R5
    wr_lane |=> (o_adv_lane_count == $past(i_wdata[LANE_W-1:0])))
    else $error("lane count not advertised after write");

  // R1 version word readback
  rev_read_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R1
    rd_rev |=> (o_rdata == rev_word))
    else $error("version word read wrong");

  // R2 protocol fields readback
  proto_read_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R2
    rd_proto |=> (o_rdata[31:8] == proto_word[31:8]))
    else $error("identity word read wrong");

  // R3 role byte receive
  role_byte_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R3
    rd_proto |=> (o_rdata[7:0] == SILC_ROLE_RX))
    else $error("role byte not receive");

  // R6 identity writes dropped
  id_write_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R6
    (i_wr && (sel_rev || sel_proto)) |=>
      ($stable(o_adv_link_rate) && $stable(o_adv_lane_count)))
    else $error("identity write disturbed state");

  // R4 rate holds otherwise
  rate_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R4
    !wr_rate |=> $stable(o_adv_link_rate))
    else $error("link rate changed without write");

  // R5 lanes hold otherwise
  lane_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R5
    !wr_lane |=> $stable(o_adv_lane_count))
    else $error("lane count changed without write");

  // R4 lane write spares rate
  rate_keep_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R4
    wr_lane |=> $stable(o_adv_link_rate))
    else $error("lane count write moved link rate");

  // R5 rate write spares lanes
  lane_keep_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R5
    wr_rate |=> $stable(o_adv_lane_count))
    else $error("link rate write moved lane count");

  // R4 rate readback matches
  rate_read_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R4
    rd_rate |=> (o_rdata == SILC_DW'(o_adv_link_rate)))
    else $error("link rate readback differs");

  // R5 lane readback matches
  lane_read_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R5
    rd_lane |=> (o_rdata == SILC_DW'(o_adv_lane_count)))
    else $error("lane count readback differs");

  // R6 read port idles
  rdata_idle_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R6
    !i_rd |=> (o_rdata == SILC_RD_UNMAPPED))
    else $error("read data not zero without read");

  // R6 unmapped reads zero
  unmapped_rd_a: assert property (@(posedge i_mclk) disable iff (!i_nrst) // R6
    rd_none |=> (o_rdata == SILC_RD_UNMAPPED))
    else $error("unmapped read not zero");

  // R4 rate reset default
  rate_rst_a: assert property (@(posedge i_mclk) // R4
    !i_nrst |=> (o_adv_link_rate == rate_rst))
    else $error("link rate not at default after reset");

  // R5 lanes reset default
  lane_rst_a: assert property (@(posedge i_mclk) // R5
    !i_nrst |=> (o_adv_lane_count == lane_rst))
    else $error("lane count not at default after reset");

  // R6 read port reset
  rdata_rst_a: assert property (@(posedge i_mclk) // R6
    !i_nrst |=> (o_rdata == SILC_RD_UNMAPPED))
    else $error("read data not zero after reset");
endmodule

// [testbench/silc_regs_tb_top.sv]
// bench for the identity and capability register bank
`timescale 1ns/1ps
module silc_regs_tb_top;
  import silc_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata, got, d;
  logic [7:0] o_adv_link_rate, seen_rate;
  logic [4:0] o_adv_lane_count, seen_lanes;
  int n_mismatch = 0;
  int checks_done = 0;
  silc_regs u_silc_regs (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_adv_link_rate(o_adv_link_rate), .o_adv_lane_count(o_adv_lane_count));
  silc_src_model u_silc_src_model (.i_mclk(i_mclk), .i_rate(o_adv_link_rate),
    .i_lanes(o_adv_lane_count), .o_seen_rate(seen_rate), .o_seen_lanes(seen_lanes));
  // clock at 100 ns period
  initial forever #50 i_mclk = ~i_mclk;
  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog at 5000 cycles, far beyond the seventy or so cycles used
  initial
  begin
    #(5000 * 100);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
    #1 chk({24'h0, o_adv_link_rate}, {24'h0, SILC_LINK_RATE_RST});
    chk({27'h0, o_adv_lane_count}, {27'h0, SILC_LANE_CNT_RST});
    // identity words, then attempts to overwrite them
    for (int k = 0; k < 2; k++)
    begin
      rd(SILC_OFF_REV_INFO);
      chk(got, 32'h0100_0000);
      rd(SILC_OFF_PROTO_ID);
      chk(got, {24'h01_0000, SILC_ROLE_RX});
      chk({24'h0, got[7:0]}, {24'h0, SILC_ROLE_RX});
      @(posedge i_mclk);
      #1 chk(o_rdata, 32'h0000_0000);
      wr(SILC_OFF_REV_INFO, 32'hFFFF_FFFF);
      wr(SILC_OFF_PROTO_ID, 32'hFFFF_FFFF);
    end
    // capability values, upper bits must drop
    for (int k = 0; k < 3; k++)
    begin
      d = (k == 0) ? 32'hFFFF_FF35 : (k == 1) ? 32'h1234_56C1 : 32'h0000_0000;
      wr(SILC_OFF_LINK_RATE, d);
      wr(SILC_OFF_LANE_CNT, ~d);
      rd(SILC_OFF_LINK_RATE);
      chk(got, {24'h0, d[7:0]});
      rd(SILC_OFF_LANE_CNT);
      chk(got, {27'h0, ~d[4:0]});
      chk({24'h0, seen_rate}, {24'h0, d[7:0]});
      chk({27'h0, seen_lanes}, {27'h0, ~d[4:0]});
    end
    // mid-run reset must bring both capability words back to defaults
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(SILC_OFF_LINK_RATE);
    chk(got, {24'h0, SILC_LINK_RATE_RST});
    rd(SILC_OFF_LANE_CNT);
    chk(got, {27'h0, SILC_LANE_CNT_RST});
    chk({24'h0, seen_rate}, {24'h0, SILC_LINK_RATE_RST});
    chk({27'h0, seen_lanes}, {27'h0, SILC_LANE_CNT_RST});
    rd(12'h0A4);
    chk(got, SILC_RD_UNMAPPED);
    end_of_test();
  end
endmodule

// [testbench/silc_src_model.sv]
// source side model that fetches the advertised capabilities
`timescale 1ns/1ps
module silc_src_model
(
  input wire logic i_mclk,
  input wire logic [7:0] i_rate,
  input wire logic [4:0] i_lanes,
  output logic [7:0] o_seen_rate,
  output logic [4:0] o_seen_lanes
);
  always_ff @(posedge i_mclk)
  begin
    o_seen_rate <= i_rate;
    o_seen_lanes <= i_lanes;
  end
endmodule
